// ### common/asc_pkg.sv
// Shared constants and types of the acquisition sync and configuration block.
package asc_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the local control bus (byte addresses).
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_BOARD_CTRL  = 16'h0000;
  localparam logic [15:0] OFS_RATE_A      = 16'h0004;
  localparam logic [15:0] OFS_RATE_B      = 16'h0008;
  localparam logic [15:0] OFS_TIMEPULSE   = 16'h001C;
  localparam logic [15:0] OFS_BUILD       = 16'h0028;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int          CTRL_INT_SEL_LSB = 8;
  localparam int          CTRL_DESYNC_BIT  = 16;
  localparam int          CTRL_SYNC_TTL_BIT = 20;
  localparam int          TP_ENABLE_BIT   = 20;
  localparam int          TP_WIDE_BIT     = 21;
  localparam int          TP_EDGE_BIT     = 22;
  localparam int          TP_VERIFIED_BIT = 24;
  localparam int          TP_RATE_LOCK_BIT = 25;
  localparam int          BLD_PLL_BIT     = 15;
  localparam int          BLD_EIGHT_BIT   = 16;
  localparam int          BLD_FOUR_BIT    = 17;
  localparam int          BLD_CUSTOM_BIT  = 18;
  localparam int          BLD_EXTTEMP_BIT = 19;
  localparam logic [2:0]  INT_SEL_RESET   = 3'h0;
  localparam logic [19:0] TARGET_RESET    = 20'h02000;
  localparam logic [31:0] RATE_RESET      = 32'h00000000;

  // ----------------------------------------------------------------
  // Interrupt event codes.
  // ----------------------------------------------------------------
  localparam logic [2:0]  EV_INIT_DONE    = 3'h0;
  localparam logic [2:0]  EV_AUTOCAL_DONE = 3'h1;
  localparam logic [2:0]  EV_CHAN_READY   = 3'h2;
  localparam logic [2:0]  EV_THRESH_RISE  = 3'h3;
  localparam logic [2:0]  EV_THRESH_FALL  = 3'h4;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned PPS_PERIOD_NS   = 1000000000;
  localparam int unsigned PPS_TOL_NS      = 1000000;
  localparam int unsigned PPS_PERIOD_CYC  = PPS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PPS_TOL_CYC     = PPS_TOL_NS / CLK_PERIOD_NS;
  localparam logic [20:0] CORR_NARROW     = 21'h000001;
  localparam logic [20:0] CORR_WIDE       = 21'h000005;

  typedef enum logic [1:0] {
    ASC_PPS_IDLE   = 2'h0,
    ASC_PPS_SEEK   = 2'h1,
    ASC_PPS_VERIFY = 2'h3,
    ASC_PPS_LOCKED = 2'h2
  } asc_pps_state_e;

endpackage

// ### common/asc_pps_if.sv
// Control and status bundle between the register bank and the pulse discipline engine.
`timescale 1ns/1ps
interface asc_pps_if;
  logic        discipline_on;
  logic        wide_tol;
  logic        edge_sel;
  logic [19:0] target;
  logic        verified;
  logic        rate_locked;
  logic        adj_up;
  logic        adj_dn;

  modport ctl (output discipline_on, wide_tol, edge_sel, target,
               input  verified, rate_locked, adj_up, adj_dn);
  modport eng (input  discipline_on, wide_tol, edge_sel, target,
               output verified, rate_locked, adj_up, adj_dn);
endinterface

// ### hw/asc_edge_det.sv
// Rising and falling transition detector for a group of level inputs.
`timescale 1ns/1ps
module asc_edge_det #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] sig_in,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  always_comb begin
    next_prev = sig_in;
    rise      = sig_in & ~prev;
    fall      = ~sig_in & prev;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule // asc_edge_det

// ### hw/asc_pps_engine.sv
// One-pulse-per-second verification and sample rate discipline engine.
`timescale 1ns/1ps
module asc_pps_engine #(
  parameter int unsigned PERIOD_CYC = asc_pkg::PPS_PERIOD_CYC,
  parameter int unsigned TOL_CYC    = asc_pkg::PPS_TOL_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pps_in,
  input  wire logic sample_tick,
  asc_pps_if.eng    pif
);
  localparam logic [31:0] WIN_LO = 32'(PERIOD_CYC - TOL_CYC);
  localparam logic [31:0] WIN_HI = 32'(PERIOD_CYC + TOL_CYC);

  asc_pkg::asc_pps_state_e state;
  asc_pkg::asc_pps_state_e next_state;
  logic [31:0] cyc;
  logic [31:0] next_cyc;
  logic [19:0] smp;
  logic [19:0] next_smp;
  logic        next_verified;
  logic        next_rate_locked;
  logic        next_adj_up;
  logic        next_adj_dn;
  logic        pps_rise;
  logic        pps_fall;
  logic        pps_edge;
  logic        in_window;
  logic [20:0] corr_lim;
  logic [20:0] err;

  asc_edge_det #(.WIDTH(1)) u_pps_edge (
    .mclk   (mclk),
    .rst    (rst),
    .sig_in (pps_in),
    .rise   (pps_rise),
    .fall   (pps_fall)
  );

  always_comb begin
    pps_edge         = pif.edge_sel ? pps_fall : pps_rise;
    in_window        = (cyc >= WIN_LO) && (cyc <= WIN_HI);
    corr_lim         = pif.wide_tol ? asc_pkg::CORR_WIDE : asc_pkg::CORR_NARROW;
    err              = (smp >= pif.target) ? ({1'b0, smp} - {1'b0, pif.target})
                                           : ({1'b0, pif.target} - {1'b0, smp});
    next_state       = state;
    next_cyc         = cyc + 32'h00000001;
    next_smp         = sample_tick ? smp + 20'h00001 : smp;
    next_verified    = pif.verified;
    next_rate_locked = pif.rate_locked;
    next_adj_up      = 1'b0;
    next_adj_dn      = 1'b0;
    case (state)
      asc_pkg::ASC_PPS_IDLE: begin
        next_cyc = '0;
        next_smp = '0;
        if (pif.discipline_on) begin
          next_state = asc_pkg::ASC_PPS_SEEK;
        end
      end
      asc_pkg::ASC_PPS_SEEK: begin
        if (pps_edge) begin
          // The edge cycle opens the new period, so its own tick belongs to it.
          next_state = asc_pkg::ASC_PPS_VERIFY;
          next_cyc   = 32'h00000001;
          next_smp   = {19'h00000, sample_tick};
        end
      end
      asc_pkg::ASC_PPS_VERIFY: begin
        if (pps_edge) begin
          next_cyc = 32'h00000001;
          next_smp = {19'h00000, sample_tick};
          if (in_window) begin
            next_state    = asc_pkg::ASC_PPS_LOCKED;
            next_verified = 1'b1;
          end
        end else if (cyc > WIN_HI) begin
          next_state = asc_pkg::ASC_PPS_SEEK;
        end
      end
      asc_pkg::ASC_PPS_LOCKED: begin
        if (pps_edge) begin
          next_cyc = 32'h00000001;
          next_smp = {19'h00000, sample_tick};
          if (!in_window) begin
            next_state       = asc_pkg::ASC_PPS_VERIFY;
            next_verified    = 1'b0;
            next_rate_locked = 1'b0;
          end else begin
            next_rate_locked = (err <= corr_lim);
            next_adj_up      = (smp < pif.target);
            next_adj_dn      = (smp > pif.target);
          end
        end else if (cyc > WIN_HI) begin
          next_state       = asc_pkg::ASC_PPS_SEEK;
          next_verified    = 1'b0;
          next_rate_locked = 1'b0;
        end
      end
      default: begin
        next_state = asc_pkg::ASC_PPS_IDLE;
      end
    endcase
    if (!pif.discipline_on) begin
      next_state       = asc_pkg::ASC_PPS_IDLE;
      next_verified    = 1'b0;
      next_rate_locked = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state           <= asc_pkg::ASC_PPS_IDLE;
      cyc             <= '0;
      smp             <= '0;
      pif.verified    <= 1'b0;
      pif.rate_locked <= 1'b0;
      pif.adj_up      <= 1'b0;
      pif.adj_dn      <= 1'b0;
    end else begin
      state           <= next_state;
      cyc             <= next_cyc;
      smp             <= next_smp;
      pif.verified    <= next_verified;
      pif.rate_locked <= next_rate_locked;
      pif.adj_up      <= next_adj_up;
      pif.adj_dn      <= next_adj_dn;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_LOCK_CLEARED_WHEN_OFF: assert property (!pif.discipline_on |=>
    (!pif.verified && !pif.rate_locked)) else $error("Lock bits set while discipline is off.");
  AST_RATE_LOCK_NEEDS_PULSE: assert property (pif.rate_locked |-> pif.verified)
    else $error("Rate lock reported without a verified pulse.");
  AST_VERIFY_ON_EDGE: assert property ($rose(pif.verified) |->
    $past(pps_edge) && $past(in_window)) else $error("Pulse verified without a timed edge.");
endmodule // asc_pps_engine

// ### hw/asc_top.sv
// Register bank, event select, scan and sync control, build options and pulse discipline.
//
// What this block does
// - Event codes 0,1,2: init, autocal, channels ready.
// - Codes 3/4: threshold rise/fall; 5-7 reserved.
// - Reset synchronized scans; desync bit high disables.
// - Level select high TTL, low LVDS.
// - Build word low bits hold firmware revision.
// - Build bit 15 high for PLL generators.
// - Bits 16/17 flag eight/four channel builds.
// - Bit 18 flags custom filter frequencies.
// - Bit 19 flags extended temperature build.
// - Twenty-bit sample target, default 0x02000.
// - Discipline on: follow pulse on sync input.
// - Discipline off: plain external sync input.
// - Correction tolerance five wide, else one.
// - Edge select low rising, high falling.
// - Verified bit rises after pulse checked.
// - Rate lock bit while rate locked.
// - Generator A at 0x4, B at 0x8.
`timescale 1ns/1ps
module asc_top #(
  parameter int unsigned PPS_PERIOD_CYC = asc_pkg::PPS_PERIOD_CYC,
  parameter int unsigned PPS_TOL_CYC    = asc_pkg::PPS_TOL_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] loc_addr,
  input  wire logic        loc_wr,
  input  wire logic        loc_rd,
  input  wire logic [31:0] loc_wdata,
  output logic      [31:0] loc_rdata,
  output logic             loc_ack,
  input  wire logic        init_done,
  input  wire logic        autocal_done,
  input  wire logic        chan_ready,
  input  wire logic        buf_thresh_flag,
  output logic             irq_event,
  output logic             scan_synchronized,
  output logic             sync_io_level_select,
  output logic      [31:0] rate_gen_a_control,
  output logic      [31:0] rate_gen_b_control,
  input  wire logic        ext_sync_in_pos_pin,
  input  wire logic        sample_tick,
  output logic             ext_sync_trig,
  output logic             rate_adj_up,
  output logic             rate_adj_dn,
  input  wire logic [14:0] strap_fw_rev,
  input  wire logic        strap_pll_gen,
  input  wire logic        strap_eight_chan,
  input  wire logic        strap_four_chan,
  input  wire logic        strap_custom_filter,
  input  wire logic        strap_ext_temp
);
  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [2:0]  int_sel;
  logic [2:0]  next_int_sel;
  logic        scan_desync_ctrl;
  logic        next_scan_desync_ctrl;
  logic        next_sync_io_level_select;
  logic [31:0] next_rate_gen_a_control;
  logic [31:0] next_rate_gen_b_control;
  logic [19:0] target;
  logic [19:0] next_target;
  logic        timepulse_discipline_on;
  logic        next_timepulse_discipline_on;
  logic        wide_tol;
  logic        next_wide_tol;
  logic        timepulse_edge_select;
  logic        next_timepulse_edge_select;
  logic [31:0] board_build_options;
  logic [31:0] next_board_build_options;
  logic        straps_taken;
  logic        next_straps_taken;
  logic [31:0] next_loc_rdata;
  logic        next_loc_ack;
  logic        next_irq_event;
  logic        next_ext_sync_trig;
  logic [31:0] board_control_word;
  logic [31:0] timepulse_sync_control;
  logic [3:0]  ev_rise;
  logic [3:0]  ev_fall;
  logic        sync_rise;
  logic        sync_fall;
  logic        hit_ctrl;
  logic        hit_rate_a;
  logic        hit_rate_b;
  logic        hit_tp;
  logic        hit_build;

  asc_pps_if pif ();

  asc_edge_det #(.WIDTH(4)) u_event_edges (
    .mclk   (mclk),
    .rst    (rst),
    .sig_in ({buf_thresh_flag, chan_ready, autocal_done, init_done}),
    .rise   (ev_rise),
    .fall   (ev_fall)
  );

  asc_edge_det #(.WIDTH(1)) u_sync_edge (
    .mclk   (mclk),
    .rst    (rst),
    .sig_in (ext_sync_in_pos_pin),
    .rise   (sync_rise),
    .fall   (sync_fall)
  );

  asc_pps_engine #(
    .PERIOD_CYC (PPS_PERIOD_CYC),
    .TOL_CYC    (PPS_TOL_CYC)
  ) u_pps (
    .mclk        (mclk),
    .rst         (rst),
    .pps_in      (ext_sync_in_pos_pin),
    .sample_tick (sample_tick),
    .pif         (pif)
  );

  assign pif.discipline_on = timepulse_discipline_on;
  assign pif.wide_tol      = wide_tol;
  assign pif.edge_sel      = timepulse_edge_select;
  assign pif.target        = target;
  assign rate_adj_up       = pif.adj_up;
  assign rate_adj_dn       = pif.adj_dn;

  // ----------------------------------------------------------------
  // Address decode and register writes.
  // ----------------------------------------------------------------
  always_comb begin
    hit_ctrl   = 1'b0;
    hit_rate_a = 1'b0;
    hit_rate_b = 1'b0;
    hit_tp     = 1'b0;
    hit_build  = 1'b0;
    if (loc_addr == asc_pkg::OFS_BOARD_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (loc_addr == asc_pkg::OFS_RATE_A) begin
      hit_rate_a = 1'b1;
    end else if (loc_addr == asc_pkg::OFS_RATE_B) begin
      hit_rate_b = 1'b1;
    end else if (loc_addr == asc_pkg::OFS_TIMEPULSE) begin
      hit_tp = 1'b1;
    end else if (loc_addr == asc_pkg::OFS_BUILD) begin
      hit_build = 1'b1;
    end
  end

  always_comb begin
    next_int_sel                 = int_sel;
    next_scan_desync_ctrl        = scan_desync_ctrl;
    next_sync_io_level_select    = sync_io_level_select;
    next_rate_gen_a_control      = rate_gen_a_control;
    next_rate_gen_b_control      = rate_gen_b_control;
    next_target                  = target;
    next_timepulse_discipline_on = timepulse_discipline_on;
    next_wide_tol                = wide_tol;
    next_timepulse_edge_select   = timepulse_edge_select;
    if (loc_wr && hit_ctrl) begin
      next_int_sel              = loc_wdata[asc_pkg::CTRL_INT_SEL_LSB +: 3];
      next_scan_desync_ctrl     = loc_wdata[asc_pkg::CTRL_DESYNC_BIT];
      next_sync_io_level_select = loc_wdata[asc_pkg::CTRL_SYNC_TTL_BIT];
    end
    if (loc_wr && hit_rate_a) begin
      next_rate_gen_a_control = loc_wdata;
    end
    if (loc_wr && hit_rate_b) begin
      next_rate_gen_b_control = loc_wdata;
    end
    if (loc_wr && hit_tp) begin
      next_target                  = loc_wdata[19:0];
      next_timepulse_discipline_on = loc_wdata[asc_pkg::TP_ENABLE_BIT];
      next_wide_tol                = loc_wdata[asc_pkg::TP_WIDE_BIT];
      next_timepulse_edge_select   = loc_wdata[asc_pkg::TP_EDGE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Build options, caught once after reset release.
  // ----------------------------------------------------------------
  // Straps are sampled on the first clock after reset, never inside the reset branch.
  always_comb begin
    next_straps_taken        = 1'b1;
    next_board_build_options = board_build_options;
    if (!straps_taken) begin
      next_board_build_options                           = '0;
      next_board_build_options[14:0]                     = strap_fw_rev;
      next_board_build_options[asc_pkg::BLD_PLL_BIT]     = strap_pll_gen;
      next_board_build_options[asc_pkg::BLD_EIGHT_BIT]   = strap_eight_chan;
      next_board_build_options[asc_pkg::BLD_FOUR_BIT]    = strap_four_chan;
      next_board_build_options[asc_pkg::BLD_CUSTOM_BIT]  = strap_custom_filter;
      next_board_build_options[asc_pkg::BLD_EXTTEMP_BIT] = strap_ext_temp;
    end
  end

  // ----------------------------------------------------------------
  // Read path, event select and plain sync.
  // ----------------------------------------------------------------
  always_comb begin
    board_control_word                                 = '0;
    board_control_word[asc_pkg::CTRL_INT_SEL_LSB +: 3] = int_sel;
    board_control_word[asc_pkg::CTRL_DESYNC_BIT]       = scan_desync_ctrl;
    board_control_word[asc_pkg::CTRL_SYNC_TTL_BIT]     = sync_io_level_select;
    timepulse_sync_control                             = '0;
    timepulse_sync_control[19:0]                       = target;
    timepulse_sync_control[asc_pkg::TP_ENABLE_BIT]     = timepulse_discipline_on;
    timepulse_sync_control[asc_pkg::TP_WIDE_BIT]       = wide_tol;
    timepulse_sync_control[asc_pkg::TP_EDGE_BIT]       = timepulse_edge_select;
    timepulse_sync_control[asc_pkg::TP_VERIFIED_BIT]   = pif.verified;
    timepulse_sync_control[asc_pkg::TP_RATE_LOCK_BIT]  = pif.rate_locked;
    next_loc_ack   = loc_rd;
    next_loc_rdata = '0;
    if (loc_rd && hit_ctrl) begin
      next_loc_rdata = board_control_word;
    end else if (loc_rd && hit_rate_a) begin
      next_loc_rdata = rate_gen_a_control;
    end else if (loc_rd && hit_rate_b) begin
      next_loc_rdata = rate_gen_b_control;
    end else if (loc_rd && hit_tp) begin
      next_loc_rdata = timepulse_sync_control;
    end else if (loc_rd && hit_build) begin
      next_loc_rdata = board_build_options;
    end
    case (int_sel)
      asc_pkg::EV_INIT_DONE:    next_irq_event = ev_rise[0];
      asc_pkg::EV_AUTOCAL_DONE: next_irq_event = ev_rise[1];
      asc_pkg::EV_CHAN_READY:   next_irq_event = ev_rise[2];
      asc_pkg::EV_THRESH_RISE:  next_irq_event = ev_rise[3];
      asc_pkg::EV_THRESH_FALL:  next_irq_event = ev_fall[3];
      default:                  next_irq_event = 1'b0;
    endcase
    // Pulses on the pin reach both the engine and the sync edge detector; the trigger is masked so no sync fires while disciplining.
    next_ext_sync_trig = !timepulse_discipline_on && sync_rise;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_sel                 <= asc_pkg::INT_SEL_RESET;
      scan_desync_ctrl        <= 1'b0;
      sync_io_level_select    <= 1'b0;
      rate_gen_a_control      <= asc_pkg::RATE_RESET;
      rate_gen_b_control      <= asc_pkg::RATE_RESET;
      target                  <= asc_pkg::TARGET_RESET;
      timepulse_discipline_on <= 1'b0;
      wide_tol                <= 1'b0;
      timepulse_edge_select   <= 1'b0;
      board_build_options     <= '0;
      straps_taken            <= 1'b0;
      loc_rdata               <= '0;
      loc_ack                 <= 1'b0;
      irq_event               <= 1'b0;
      ext_sync_trig           <= 1'b0;
      scan_synchronized       <= 1'b1;
    end else begin
      int_sel                 <= next_int_sel;
      scan_desync_ctrl        <= next_scan_desync_ctrl;
      sync_io_level_select    <= next_sync_io_level_select;
      rate_gen_a_control      <= next_rate_gen_a_control;
      rate_gen_b_control      <= next_rate_gen_b_control;
      target                  <= next_target;
      timepulse_discipline_on <= next_timepulse_discipline_on;
      wide_tol                <= next_wide_tol;
      timepulse_edge_select   <= next_timepulse_edge_select;
      board_build_options     <= next_board_build_options;
      straps_taken            <= next_straps_taken;
      loc_rdata               <= next_loc_rdata;
      loc_ack                 <= next_loc_ack;
      irq_event               <= next_irq_event;
      ext_sync_trig           <= next_ext_sync_trig;
      scan_synchronized       <= !next_scan_desync_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence init_edge_s;
    (int_sel == asc_pkg::EV_INIT_DONE) && init_done && !$past(init_done);
  endsequence

  AST_INIT_EVENT_ONE_CLOCK: assert property (init_edge_s |=> irq_event ##1 !irq_event)
    else $error("Init event not signalled exactly once.");
  AST_THRESH_FALL_EVENT: assert property ((int_sel == asc_pkg::EV_THRESH_FALL) &&
    !buf_thresh_flag && $past(buf_thresh_flag) |=> irq_event)
    else $error("Threshold fall not signalled.");
  AST_RESERVED_CODES_SILENT: assert property (irq_event |-> $past(int_sel) <= 3'h4)
    else $error("Event raised for a reserved code.");
  AST_DESYNC_WRITE: assert property (loc_wr && hit_ctrl |=>
    scan_synchronized == !$past(loc_wdata[16])) else $error("Scan mode did not follow write.");
  AST_LEVEL_SELECT_WRITE: assert property (loc_wr && hit_ctrl |=>
    sync_io_level_select == $past(loc_wdata[20])) else $error("Level select did not follow.");
  AST_BUILD_READ: assert property (straps_taken && loc_rd && hit_build |=>
    loc_ack && loc_rdata == board_build_options && loc_rdata[31:20] == 12'h000)
    else $error("Build word read wrong.");
  AST_TARGET_READBACK: assert property (loc_wr && hit_tp ##2 loc_rd && hit_tp |=>
    loc_rdata[19:0] == $past(loc_wdata[19:0], 3) && loc_rdata[31:26] == 6'h00 && !loc_rdata[23])
    else $error("Target readback wrong.");
  AST_PLAIN_SYNC_ONLY_WHEN_OFF: assert property (ext_sync_trig |->
    !$past(timepulse_discipline_on)) else $error("Plain sync fired while disciplining.");
  AST_RATE_A_WRITE: assert property (loc_wr && hit_rate_a |=>
    rate_gen_a_control == $past(loc_wdata) &&
    rate_gen_b_control == $past(rate_gen_b_control))
    else $error("Generator A control not written.");
endmodule // asc_top

// ### tb/asc_pps_src.sv
// Once-per-period pulse source standing in for the satellite timing receiver.
`timescale 1ns/1ps
module asc_pps_src #(
  parameter int unsigned PERIOD = 200
) (
  input  wire logic mclk,
  input  wire logic en,
  output logic      pin
);
  // The line idles low while the source is off, as an unpowered receiver would leave it.
  int unsigned cnt = 0;
  initial pin = 1'b0;
  always @(posedge mclk) begin
    cnt <= (!en || cnt == PERIOD - 1) ? 0 : cnt + 1;
    pin <= en && cnt < 10;
  end
endmodule // asc_pps_src

// ### tb/tb_asc_top.sv
// Register level bench of the acquisition sync and configuration block.
`timescale 1ns/1ps
module tb_asc_top;
  // ----------------------------------------------------------------
  // Stimulus, partner and checks.
  // ----------------------------------------------------------------
  localparam int unsigned PER = 200;
  logic mclk = 0, rst = 1, loc_wr = 0, loc_rd = 0, loc_ack, irq_event, scan_synchronized;
  logic [15:0] loc_addr = 16'h0000;
  logic [31:0] loc_wdata = 32'h00000000, loc_rdata, rate_gen_a_control, rate_gen_b_control;
  logic init_done = 0, autocal_done = 0, chan_ready = 0, buf_thresh_flag = 0, src_en = 0;
  logic sync_io_level_select, ext_sync_in_pos_pin, ext_sync_trig, rate_adj_up, rate_adj_dn;
  logic tick = 1;
  logic [19:0] straps = 20'hA9234;
  int num_errors = 0, cmp_count = 0, irq_n = 0, trig_n = 0, cyc = 0, up_n = 0, dn_n = 0;
  int irq0, trig0, up0, dn0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    irq_n <= irq_n + (irq_event === 1'b1);
    trig_n <= trig_n + (ext_sync_trig === 1'b1);
    up_n <= up_n + (rate_adj_up === 1'b1);
    dn_n <= dn_n + (rate_adj_dn === 1'b1);
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  asc_pps_src #(.PERIOD(PER)) src (.mclk, .en(src_en), .pin(ext_sync_in_pos_pin));
  asc_top #(.PPS_PERIOD_CYC(PER), .PPS_TOL_CYC(10)) dut (.mclk, .rst, .loc_addr, .loc_wr,
    .loc_rd, .loc_wdata, .loc_rdata, .loc_ack, .init_done, .autocal_done, .chan_ready,
    .buf_thresh_flag, .irq_event, .scan_synchronized, .sync_io_level_select,
    .rate_gen_a_control, .rate_gen_b_control, .ext_sync_in_pos_pin, .sample_tick(tick),
    .ext_sync_trig, .rate_adj_up, .rate_adj_dn, .strap_fw_rev(straps[14:0]),
    .strap_pll_gen(straps[15]), .strap_eight_chan(straps[16]), .strap_four_chan(straps[17]),
    .strap_custom_filter(straps[18]), .strap_ext_temp(straps[19]));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk) {loc_wr, loc_addr, loc_wdata} <= {1'b1, a, d};
    @(posedge mclk) loc_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge mclk) {loc_rd, loc_addr} <= {1'b1, a};
    @(posedge mclk) loc_rd <= 1'b0;
    #1 chk({31'h0, loc_ack}, 32'h1);
    chk(loc_rdata, exp);
  endtask
  task automatic results();
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk) #1 chk({30'h0, scan_synchronized, sync_io_level_select}, 32'h2);
    rd(16'h001C, 32'h00002000);
    rd(16'h0028, 32'h000A9234);
    rd(16'h0030, 32'h00000000);
    wr(16'h0000, 32'h00110000);
    #1 chk({30'h0, scan_synchronized, sync_io_level_select}, 32'h1);
    wr(16'h0004, 32'hA5A5F00F);
    wr(16'h0008, 32'h5A5A0FF0);
    #1 chk(rate_gen_a_control, 32'hA5A5F00F);
    chk(rate_gen_b_control, 32'h5A5A0FF0);
    rd(16'h0008, 32'h5A5A0FF0);
    wr(16'h001C, 32'hFFFFFFFF);
    rd(16'h001C, 32'h007FFFFF);
    for (int c = 0; c < 6; c++) begin
      wr(16'h0000, 32'(c) << 8);
      repeat (3) @(posedge mclk);
      irq0 = irq_n;
      {init_done, autocal_done, chan_ready, buf_thresh_flag} <= 4'hF;
      repeat (4) @(posedge mclk) {init_done, autocal_done, chan_ready, buf_thresh_flag} <= 4'h0;
      repeat (4) @(posedge mclk);
      chk(irq_n - irq0, (c < 5) ? 32'h1 : 32'h0);
    end
    wr(16'h001C, 32'h007000C8);
    src_en <= 1'b1;
    repeat (4 * PER) @(posedge mclk);
    rd(16'h001C, 32'h037000C8);
    wr(16'h001C, 32'h005000C5);
    dn0 = dn_n;
    repeat (2 * PER) @(posedge mclk);
    rd(16'h001C, 32'h015000C5);
    chk(32'(dn_n > dn0), 32'h1);
    wr(16'h001C, 32'h007000C5);
    repeat (2 * PER) @(posedge mclk);
    rd(16'h001C, 32'h037000C5);
    @(posedge mclk) tick <= 1'b0;
    up0 = up_n;
    repeat (2 * PER) @(posedge mclk);
    rd(16'h001C, 32'h017000C5);
    chk(32'(up_n > up0), 32'h1);
    @(posedge mclk) tick <= 1'b1;
    wr(16'h001C, 32'h000000C8);
    rd(16'h001C, 32'h000000C8);
    trig0 = trig_n;
    repeat (2 * PER) @(posedge mclk);
    #1 chk(trig_n - trig0, 32'h2);
    @(posedge mclk) {rst, straps} <= {1'b1, 20'h56DCB};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(16'h0028, 32'h00056DCB);
    chk(rate_gen_a_control, 32'h00000000);
    rd(16'h001C, 32'h00002000);
    results();
  end
endmodule // tb_asc_top
